// File: include/tcp_pkg.sv
package tcp_pkg;
	// Register byte addresses on the APB bus
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CTRL1 = 8'h04;
	localparam logic [7:0] ADDR_CTRL2 = 8'h08;
	localparam logic [7:0] ADDR_CMP1_HI = 8'h0C;
	localparam logic [7:0] ADDR_CMP1_LO = 8'h10;
	localparam logic [7:0] ADDR_CMP2_HI = 8'h14;
	localparam logic [7:0] ADDR_CMP2_LO = 8'h18;
	localparam logic [7:0] ADDR_CAP1_HI = 8'h1C;
	localparam logic [7:0] ADDR_CAP1_LO = 8'h20;
	localparam logic [7:0] ADDR_CAP2_HI = 8'h24;
	localparam logic [7:0] ADDR_CAP2_LO = 8'h28;
	localparam logic [7:0] ADDR_CNT_HI = 8'h2C;
	localparam logic [7:0] ADDR_CNT_LO = 8'h30;
	// Control register 1 fields
	localparam int C1_CAP_IRQ_EN = 7;
	localparam int C1_CMP_IRQ_EN = 6;
	localparam int C1_OVF_IRQ_EN = 5;
	localparam int C1_FORCE_2 = 4;
	localparam int C1_FORCE_1 = 3;
	localparam int C1_LEVEL_2 = 2;
	localparam int C1_EDGE_1 = 1;
	localparam int C1_LEVEL_1 = 0;
	// Control register 2 fields
	localparam int C2_PIN_EN_1 = 7;
	localparam int C2_PIN_EN_2 = 6;
	localparam int C2_SINGLE_PULSE = 5;
	localparam int C2_PWM = 4;
	localparam int C2_CLK_SEL = 2;
	localparam int C2_EDGE_2 = 1;
	localparam int C2_EXT_EDGE = 0;
	// Status register fields
	localparam int ST_CAP_1 = 7;
	localparam int ST_CMP_1 = 6;
	localparam int ST_OVF = 5;
	localparam int ST_CAP_2 = 4;
	localparam int ST_CMP_2 = 3;
	// Clock select codes
	localparam logic [1:0] CLK_DIV4 = 2'h0;
	localparam logic [1:0] CLK_DIV2 = 2'h1;
	localparam logic [1:0] CLK_DIV8 = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;
	// Reset, reload and pulse capture values
	localparam logic [15:0] CMP_RESET = 16'h8000;
	localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
	localparam logic [15:0] PULSE_CAPTURE = 16'hFFFD;
	localparam logic [2:0] PRE_RESET = 3'h0;
	// Mode of the compare section
	typedef enum logic [1:0]
	{
		MODE_CMP = 2'b00,
		MODE_PULSE = 2'b01,
		MODE_PWM = 2'b10
	} tcp_mode_t;
endpackage

// File: core/tcp_timer.sv
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Function
// - Match sets flag, drives level to pin
// - Pin latches low in reset until compare
// - Compare irq needs enable and clear mask
// - Flag clears: status read, then low access
// - High write suspends compare until low write
// - Pin enable clear: pin ignores level
// - Div2 matches equal, others equal plus one
// - Force copies level, no flag, no irq
// - Force ignored in pulse or PWM
// - Pulse trigger: reload, level2 out, capture
// - Pulse ends on first compare match
// - Pulse mode: no flag1, channel2 pinless
// - Pulse trigger sets capture flag 1
// - PWM wins over pulse mode
// - PWM second match reloads counter
// - PWM pin takes level1 then level2
// - PWM sets no compare flags
// - PWM period end sets capture flag 1
// - PWM detaches capture pin 1 only
// - Equal levels give steady pin
// - Clock select: div4, div2, div8, external
// - All sources share one gated irq
module tcp_timer
	import tcp_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Processor and pins
	input wire logic i_cpu_irq_mask,
	input wire logic i_ext_clk,
	input wire logic i_capture_in_pin_1,
	input wire logic i_capture_in_pin_2,
	output logic o_compare_out_pin_1,
	output logic o_compare_out_pin_1_oe,
	output logic o_compare_out_pin_2,
	output logic o_compare_out_pin_2_oe,
	output logic o_timer_irq
);
	typedef struct packed
	{
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [4:0] flags;
		logic [4:0] armed;
		logic [15:0] cmp1;
		logic [15:0] cmp2;
		logic [7:0] cmp1_hi;
		logic [7:0] cmp2_hi;
		logic [1:0] cmp_hold;
		logic [15:0] cap1;
		logic [15:0] cap2;
		logic [1:0] cap_hold;
		logic [15:0] cnt;
		logic [2:0] pre;
		logic ext_q;
		logic cap1_q;
		logic cap2_q;
		logic [1:0] match_q;
		logic pin1;
		logic pin2;
		logic pin2_oe;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} tcp_state_t;

	tcp_state_t cur;
	tcp_state_t nxt;

	// Address check used only for the error response
	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a <= ADDR_CNT_LO) && (a[1:0] == 2'h0);
	endfunction

	tcp_mode_t mode;
	logic tick;
	logic [1:0] sel;
	logic [1:0] match;
	logic [1:0] hit;
	logic acc;
	logic rd;
	logic wr;
	logic trig1;
	logic edge2;
	logic cap1_ev;
	logic [15:0] ref1;
	logic [15:0] ref2;
	logic [15:0] cnt_now;
	logic [7:0] st_byte;

	// Combinational next state
	always_comb
	begin
		nxt = cur;
		sel = cur.ctrl2[C2_CLK_SEL +: 2];
		// Mode priority with PWM first
		if (cur.ctrl2[C2_PWM])
			mode = MODE_PWM;
		else if (cur.ctrl2[C2_SINGLE_PULSE])
			mode = MODE_PULSE;
		else
			mode = MODE_CMP;
		// Timer tick from the clock select
		nxt.ext_q = i_ext_clk;
		nxt.pre = cur.pre + 3'h1;
		case (sel)
			CLK_DIV2: tick = cur.pre[0];
			CLK_DIV4: tick = (cur.pre[1:0] == 2'h3);
			CLK_DIV8: tick = (cur.pre == 3'h7);
			CLK_EXT: tick = (i_ext_clk != cur.ext_q) && (i_ext_clk == cur.ctrl2[C2_EXT_EDGE]);
			default: tick = 1'b0;
		endcase
		// Match against value, plus one for slower clocks
		ref1 = (sel == CLK_DIV2) ? cur.cmp1 : cur.cmp1 + 16'h0001;
		ref2 = (sel == CLK_DIV2) ? cur.cmp2 : cur.cmp2 + 16'h0001;
		match[0] = (cur.cnt == ref1) && !cur.cmp_hold[0];
		match[1] = (cur.cnt == ref2) && !cur.cmp_hold[1];
		nxt.match_q = match;
		hit = match & ~cur.match_q;
		// Capture pin edges
		nxt.cap1_q = i_capture_in_pin_1;
		nxt.cap2_q = i_capture_in_pin_2;
		trig1 = (i_capture_in_pin_1 != cur.cap1_q)
			&& (i_capture_in_pin_1 == cur.ctrl1[C1_EDGE_1]) && (mode != MODE_PWM);
		edge2 = (i_capture_in_pin_2 != cur.cap2_q)
			&& (i_capture_in_pin_2 == cur.ctrl2[C2_EDGE_2]);
		// Any event that sets capture flag 1 this cycle, so that set beats clear
		cap1_ev = (mode == MODE_PWM) ? hit[1]
			: (mode == MODE_PULSE) ? trig1 : (trig1 && !cur.cap_hold[0]);
		// Counter
		cnt_now = cur.cnt;
		if (tick)
			cnt_now = cur.cnt + 16'h0001;
		if (tick && cur.cnt == 16'hFFFF)
			nxt.flags[ST_OVF - 3] = 1'b1;
		// Compare channels
		case (mode)
			MODE_PWM:
			begin
				if (hit[0])
					nxt.pin1 = cur.ctrl1[C1_LEVEL_1];
				if (hit[1])
				begin
					nxt.pin1 = cur.ctrl1[C1_LEVEL_2];
					cnt_now = CNT_RELOAD;
					nxt.flags[ST_CAP_1 - 3] = 1'b1;
				end
			end
			MODE_PULSE:
			begin
				if (hit[0])
					nxt.pin1 = cur.ctrl1[C1_LEVEL_1];
				if (hit[1])
					nxt.flags[ST_CMP_2 - 3] = 1'b1;
				if (trig1)
				begin
					cnt_now = CNT_RELOAD;
					nxt.pin1 = cur.ctrl1[C1_LEVEL_2];
					nxt.flags[ST_CAP_1 - 3] = 1'b1;
					nxt.cap1 = PULSE_CAPTURE;
				end
			end
			default:
			begin
				if (hit[0])
				begin
					nxt.flags[ST_CMP_1 - 3] = 1'b1;
					nxt.pin1 = cur.ctrl1[C1_LEVEL_1];
				end
				if (hit[1])
				begin
					nxt.flags[ST_CMP_2 - 3] = 1'b1;
					nxt.pin2 = cur.ctrl1[C1_LEVEL_2];
				end
				if (trig1 && !cur.cap_hold[0])
				begin
					nxt.flags[ST_CAP_1 - 3] = 1'b1;
					nxt.cap1 = cur.cnt;
				end
			end
		endcase
		if (edge2 && !cur.cap_hold[1])
		begin
			nxt.flags[ST_CAP_2 - 3] = 1'b1;
			nxt.cap2 = cur.cnt;
		end
		nxt.cnt = cnt_now;
		// APB access, answered by registered ready one cycle after it is taken
		acc = i_psel && i_penable && !cur.pready;
		rd = acc && !i_pwrite;
		wr = acc && i_pwrite;
		nxt.pready = acc;
		nxt.pslverr = acc && !known_addr(i_paddr);
		nxt.prdata = 32'h0000_0000;
		st_byte = {cur.flags[ST_CAP_1 - 3], cur.flags[ST_CMP_1 - 3], cur.flags[ST_OVF - 3],
			cur.flags[ST_CAP_2 - 3], cur.flags[ST_CMP_2 - 3], 3'h0};
		if (rd)
		begin
			case (i_paddr)
				ADDR_STATUS: nxt.prdata[7:0] = st_byte;
				ADDR_CTRL1: nxt.prdata[7:0] = cur.ctrl1;
				ADDR_CTRL2: nxt.prdata[7:0] = cur.ctrl2;
				ADDR_CMP1_HI: nxt.prdata[7:0] = cur.cmp1[15:8];
				ADDR_CMP1_LO: nxt.prdata[7:0] = cur.cmp1[7:0];
				ADDR_CMP2_HI: nxt.prdata[7:0] = cur.cmp2[15:8];
				ADDR_CMP2_LO: nxt.prdata[7:0] = cur.cmp2[7:0];
				ADDR_CAP1_HI: nxt.prdata[7:0] = cur.cap1[15:8];
				ADDR_CAP1_LO: nxt.prdata[7:0] = cur.cap1[7:0];
				ADDR_CAP2_HI: nxt.prdata[7:0] = cur.cap2[15:8];
				ADDR_CAP2_LO: nxt.prdata[7:0] = cur.cap2[7:0];
				ADDR_CNT_HI: nxt.prdata[7:0] = cur.cnt[15:8];
				ADDR_CNT_LO: nxt.prdata[7:0] = cur.cnt[7:0];
				default: nxt.prdata = 32'h0000_0000;
			endcase
			// Status read arms clearing of flags set now
			if (i_paddr == ADDR_STATUS)
				nxt.armed = cur.flags;
			if (i_paddr == ADDR_CAP1_HI)
				nxt.cap_hold[0] = 1'b1;
			if (i_paddr == ADDR_CAP2_HI)
				nxt.cap_hold[1] = 1'b1;
		end
		if (wr)
		begin
			case (i_paddr)
				ADDR_CTRL1: nxt.ctrl1 = i_pwdata[7:0];
				ADDR_CTRL2: nxt.ctrl2 = i_pwdata[7:0];
				ADDR_CMP1_HI:
				begin
					nxt.cmp1_hi = i_pwdata[7:0];
					nxt.cmp_hold[0] = 1'b1;
				end
				ADDR_CMP2_HI:
				begin
					nxt.cmp2_hi = i_pwdata[7:0];
					nxt.cmp_hold[1] = 1'b1;
				end
				ADDR_CMP1_LO:
				begin
					nxt.cmp1 = {cur.cmp1_hi, i_pwdata[7:0]};
					nxt.cmp_hold[0] = 1'b0;
				end
				ADDR_CMP2_LO:
				begin
					nxt.cmp2 = {cur.cmp2_hi, i_pwdata[7:0]};
					nxt.cmp_hold[1] = 1'b0;
				end
				ADDR_CNT_LO: nxt.cnt = CNT_RELOAD;
				default: nxt.cnt = nxt.cnt;
			endcase
			// Forced compare only in plain compare mode
			if (i_paddr == ADDR_CTRL1 && mode == MODE_CMP)
			begin
				if (i_pwdata[C1_FORCE_1])
					nxt.pin1 = i_pwdata[C1_LEVEL_1];
				if (i_pwdata[C1_FORCE_2])
					nxt.pin2 = i_pwdata[C1_LEVEL_2];
			end
		end
		// Second step of flag clearing; a new event in the same cycle wins
		if (acc)
		begin
			// The low access uses up the arming; a later clear needs a new status read
			if (i_paddr == ADDR_CMP1_LO)
			begin
				if (cur.armed[ST_CMP_1 - 3] && !hit[0])
					nxt.flags[ST_CMP_1 - 3] = 1'b0;
				nxt.armed[ST_CMP_1 - 3] = 1'b0;
			end
			if (i_paddr == ADDR_CMP2_LO)
			begin
				if (cur.armed[ST_CMP_2 - 3] && !hit[1])
					nxt.flags[ST_CMP_2 - 3] = 1'b0;
				nxt.armed[ST_CMP_2 - 3] = 1'b0;
			end
			if (i_paddr == ADDR_CNT_LO)
			begin
				if (cur.armed[ST_OVF - 3] && !(tick && cur.cnt == 16'hFFFF))
					nxt.flags[ST_OVF - 3] = 1'b0;
				nxt.armed[ST_OVF - 3] = 1'b0;
			end
			if (i_paddr == ADDR_CAP1_LO)
			begin
				nxt.cap_hold[0] = 1'b0;
				if (cur.armed[ST_CAP_1 - 3] && !cap1_ev)
					nxt.flags[ST_CAP_1 - 3] = 1'b0;
				nxt.armed[ST_CAP_1 - 3] = 1'b0;
			end
			if (i_paddr == ADDR_CAP2_LO)
			begin
				nxt.cap_hold[1] = 1'b0;
				if (cur.armed[ST_CAP_2 - 3] && !edge2)
					nxt.flags[ST_CAP_2 - 3] = 1'b0;
				nxt.armed[ST_CAP_2 - 3] = 1'b0;
			end
		end
		// Pin 2 drive enable follows the control bits registered alongside them
		nxt.pin2_oe = nxt.ctrl2[C2_PIN_EN_2] && !nxt.ctrl2[C2_PWM]
			&& !nxt.ctrl2[C2_SINGLE_PULSE];
		// Shared interrupt request
		nxt.irq = !i_cpu_irq_mask && (
			(cur.ctrl1[C1_CAP_IRQ_EN] && (cur.flags[ST_CAP_1 - 3] || cur.flags[ST_CAP_2 - 3]))
			|| (cur.ctrl1[C1_CMP_IRQ_EN] && (cur.flags[ST_CMP_1 - 3] || cur.flags[ST_CMP_2 - 3]))
			|| (cur.ctrl1[C1_OVF_IRQ_EN] && cur.flags[ST_OVF - 3]));
	end

	// State register, pins low in reset
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cur <= '0;
			cur.cmp1 <= CMP_RESET;
			cur.cmp2 <= CMP_RESET;
			cur.pre <= PRE_RESET;
		end
		else
			cur <= nxt;
	end

	// Outputs straight from flops; pin enable gates the drive
	assign o_prdata = cur.prdata;
	assign o_pready = cur.pready;
	assign o_pslverr = cur.pslverr;
	assign o_compare_out_pin_1 = cur.pin1;
	assign o_compare_out_pin_1_oe = cur.ctrl2[C2_PIN_EN_1];
	assign o_compare_out_pin_2 = cur.pin2;
	assign o_compare_out_pin_2_oe = cur.pin2_oe;
	assign o_timer_irq = cur.irq;
endmodule // tcp_timer

// File: tb/tcp_properties.sv
`timescale 1ns/100ps
// Port-level checks of the compare timer
module tcp_properties
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Bus, mask and pins
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [7:0] i_paddr,
	input wire logic i_cpu_irq_mask,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_compare_out_pin_1,
	input wire logic o_compare_out_pin_2,
	input wire logic o_timer_irq
);
	logic bad;
	// Unmapped or unaligned address
	assign bad = i_paddr > 8'h30 || i_paddr[1:0] != 2'h0;
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);
	// Access taken by the slave
	sequence taken_s;
		i_psel && i_penable && !o_pready;
	endsequence
	sequence fresh_s;
		$rose(i_arst_n);
	endsequence
	AST_PIN_RESET: assert property (
		fresh_s |-> !o_compare_out_pin_1 && !o_compare_out_pin_2)
		else $error("pin high after reset");
	AST_READY_ANSWER: assert property (taken_s |=> o_pready)
		else $error("no ready after access");
	AST_READY_PULSE: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	AST_NO_REQUEST: assert property (!(i_psel && i_penable) |=> !o_pready)
		else $error("ready without access");
	AST_SLVERR: assert property (taken_s |=> o_pslverr == $past(bad))
		else $error("wrong error response");
	AST_ERR_READY: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	AST_UPPER_ZERO: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	AST_IRQ_MASK: assert property (i_cpu_irq_mask |=> !o_timer_irq)
		else $error("irq while masked");
endmodule // tcp_properties

bind tcp_timer tcp_properties i_tcp_properties (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
	.i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
	.i_cpu_irq_mask(i_cpu_irq_mask), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_compare_out_pin_1(o_compare_out_pin_1),
	.o_compare_out_pin_2(o_compare_out_pin_2), .o_timer_irq(o_timer_irq));

// File: tb/tcp_pins.sv
`timescale 1ns/100ps
// External circuitry on the capture and tick pins
module tcp_pins
(
	// Clock and command
	input wire logic i_mclk,
	input wire logic i_fire_1,
	// Pins
	output logic o_cap_1,
	output logic o_cap_2,
	output logic o_ext_clk
);
	logic [2:0] div = 3'h0;
	logic cap = 1'b0;
	assign o_cap_1 = cap;
	assign o_cap_2 = div[2] ^ div[1];
	assign o_ext_clk = div[2];
	// Tick every eight cycles, capture 1 edge on command
	always @(posedge i_mclk)
	begin
		div <= div + 3'h1;
		if (i_fire_1)
			cap <= !cap;
	end
endmodule // tcp_pins

// File: tb/timer_compare_pulse_pwm_test.sv
`timescale 1ns/100ps
// Self-checking bench of the compare timer
module timer_compare_pulse_pwm_test
	import tcp_pkg::*;
	;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic mask = 1'b0;
	logic fire = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, pin1, irq, ext, cap1, cap2, lvl;
	logic pin2, oe1, oe2;
	logic [7:0] rd = 8'h00;
	logic [16:0] note;
	logic [16:0] notes[$];
	logic [1:0] seen;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	tcp_timer i_tcp_timer (.i_mclk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_cpu_irq_mask(mask), .i_ext_clk(ext),
		.i_capture_in_pin_1(cap1), .i_capture_in_pin_2(cap2), .o_compare_out_pin_1(pin1),
		.o_compare_out_pin_1_oe(oe1), .o_compare_out_pin_2(pin2), .o_compare_out_pin_2_oe(oe2),
		.o_timer_irq(irq));
	tcp_pins i_tcp_pins (.i_mclk(clk), .i_fire_1(fire), .o_cap_1(cap1), .o_cap_2(cap2),
		.o_ext_clk(ext));
	always #12.5 clk = !clk;
	task automatic end_sim;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// One APB transfer; the note says what the answer must hold
	task automatic apb(input logic w, input logic [7:0] a, d, input logic [16:0] n);
		notes.push_back(n);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wx(input logic [7:0] a, d);
		apb(1'b1, a, d, 17'h0);
	endtask
	task automatic rx(input logic [7:0] a, m, v);
		apb(1'b0, a, 8'h00, {1'b0, m, v});
	endtask
	task automatic poll(input int b);
		rd = 8'h00;
		for (int k = 0; k < 80 && rd[b] !== 1'b1; k++)
			rx(ADDR_STATUS, 8'h00, 8'h00);
	endtask
	// Match each answer against the oldest note
	always @(posedge clk)
		if (pready)
		begin
			note = notes.pop_front();
			chk("pslverr", 8'(note[16]), 8'(pslverr));
			chk("prdata", note[7:0], prdata[7:0] & note[15:8]);
		end
	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			end_sim();
		end
	end
	initial
	begin
		void'($urandom(32'hDC461D1C));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rx(ADDR_CTRL1, 8'hFF, 8'h00);
		rx(ADDR_CMP1_HI, 8'hFF, 8'h80);
		apb(1'b0, 8'h34, 8'h00, {1'b1, 8'hFF, 8'h00});
		// Compare match under every tick source
		for (int i = 0; i < 4; i++)
		begin
			lvl = !i[0];
			mask <= i[1];
			wx(ADDR_CTRL2, {4'h8, 2'(i), 2'h0});
			wx(ADDR_CTRL1, {7'h20, lvl});
			wx(ADDR_CMP1_HI, 8'h00);
			wx(ADDR_CNT_LO, 8'h00);
			wx(ADDR_CMP1_LO, 8'h04 + 8'($urandom % 8));
			poll(ST_CMP_1);
			rx(ADDR_STATUS, 8'h40, 8'h40);
			chk("pin", 8'(lvl), 8'(pin1));
			chk("irq", 8'(!i[1]), 8'(irq));
			rx(ADDR_CMP1_LO, 8'h00, 8'h00);
			rx(ADDR_STATUS, 8'h40, 8'h00);
		end
		// Single pulse on a capture edge
		mask <= 1'b0;
		wx(ADDR_CMP1_LO, 8'h40);
		wx(ADDR_CTRL1, 8'h06);
		wx(ADDR_CTRL2, 8'hA4);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (10) @(posedge clk);
		chk("pin", 8'h01, 8'(pin1));
		rx(ADDR_STATUS, 8'hC0, 8'h80);
		rx(ADDR_CAP1_HI, 8'hFF, 8'hFF);
		rx(ADDR_CAP1_LO, 8'hFF, 8'hFD);
		repeat (200) @(posedge clk);
		chk("pin", 8'h00, 8'(pin1));
		wx(ADDR_CTRL1, 8'h0F);
		chk("pin", 8'h00, 8'(pin1));
		rx(ADDR_STATUS, 8'h40, 8'h00);
		// Forced level in compare mode
		wx(ADDR_CTRL2, 8'hC0);
		wx(ADDR_CTRL1, 8'h1D);
		chk("pin", 8'h01, 8'(pin1));
		chk("pin2", 8'h01, 8'(pin2));
		chk("oe", 8'h03, 8'({oe1, oe2}));
		rx(ADDR_STATUS, 8'h48, 8'h00);
		// PWM with both mode bits set
		wx(ADDR_CMP2_HI, 8'h00);
		wx(ADDR_CMP2_LO, 8'h30);
		wx(ADDR_CMP1_LO, 8'h10);
		wx(ADDR_CTRL1, 8'h84);
		wx(ADDR_CTRL2, 8'hB4);
		wx(ADDR_CNT_LO, 8'h00);
		seen = 2'b00;
		repeat (400)
		begin
			@(posedge clk);
			seen[pin1] = 1'b1;
		end
		chk("levels", 8'h03, 8'(seen));
		rx(ADDR_STATUS, 8'hC8, 8'h80);
		rx(ADDR_STATUS, 8'h10, 8'h10);
		chk("oe2", 8'h00, 8'(oe2));
		chk("irq", 8'h01, 8'(irq));
		end_sim();
	end
endmodule // timer_compare_pulse_pwm_test
